// File: hdl/mpc_regs.svh
// offsets, field positions, reset values and timing counts for the
// multifunction port configuration block; included by bare name
`ifndef MPC_REGS_SVH
`define MPC_REGS_SVH
`define MPC_OFF_PORT_CFG_A 8'h80
`define MPC_OFF_PORT_CFG_B 8'h81
`define MPC_OFF_PORT_CFG_C 8'h82
`define MPC_OFF_PORT_CFG_D 8'h83
`define MPC_OFF_PORT_CFG_CLK 8'h84
`define MPC_OFF_CTRL 8'h90
`define MPC_OFF_STATUS 8'h91
`define MPC_RST_PORT_CFG 8'h00
`define MPC_RST_CLK_CFG 8'h00
`define MPC_RST_CTRL 8'h00
`define MPC_RX_SEL_MSB 6
`define MPC_RX_SEL_LSB 4
`define MPC_TX_SEL_MSB 3
`define MPC_TX_SEL_LSB 0
`define MPC_POL_BIT 3
`define MPC_RSVD_BIT 2
`define MPC_SYSRX_DIR_BIT 1
`define MPC_RXCLK_DIR_BIT 0
`define MPC_CTRL_INTERNAL_SYNC_PULSE_SEL_BIT 0
`define MPC_CTRL_FFS_BIT 1
`define MPC_CTRL_CASMF_BIT 2
`define MPC_CTRL_TX_SIGNALING_SLOT_MARKER_BIT 3
`define MPC_CTRL_XLT_BIT 4
`define MPC_BIT_NS 488
`define MPC_CLK_NS 10
`define MPC_BIT_CYC ((`MPC_BIT_NS + `MPC_CLK_NS - 1) / `MPC_CLK_NS)
`define MPC_BITS_FRAME 256
`define MPC_FRAMES_MF 16
`endif

// File: hdl/mpc_pkg.sv
// types shared by both ends of the multifunction port configuration link
// assumes mpc_regs.svh for numeric constants
package mpc_pkg;
    typedef logic [7:0] mpc_byte_t;
    typedef logic [2:0] mpc_rx_sel_t;
    typedef logic [3:0] mpc_tx_sel_t;
    typedef enum logic [2:0] {
        MPC_RX_SYNC_IN = 3'h0, MPC_RX_FRAME_MARK = 3'h1,
        MPC_RX_MF_START = 3'h2, MPC_RX_SIG_MARK = 3'h3,
        MPC_RX_SIG_OUT = 3'h4, MPC_RX_SPARE_MARK = 3'h5,
        MPC_RX_FREEZE = 3'h6, MPC_RX_FRAME_PULSE = 3'h7
    } mpc_rx_fn_e;
    typedef enum logic [3:0] {
        MPC_TX_SYNC_IN = 4'h0, MPC_TX_MF_SYNC_IN = 4'h1,
        MPC_TX_SIG_IN = 4'h2, MPC_TX_CLK_IN = 4'h3,
        MPC_TX_MF_START = 4'h4, MPC_TX_SIG_MARK = 4'h5,
        MPC_TX_SPARE_MARK = 4'h6, MPC_TX_LINE_CLK = 4'h7,
        MPC_TX_TRISTATE = 4'h8
    } mpc_tx_fn_e;
    typedef enum logic [2:0] {
        MPC_H_IDLE = 3'b001, MPC_H_WRITE = 3'b010, MPC_H_READ = 3'b100
    } mpc_host_state_e;
endpackage : mpc_pkg

// File: hdl/mpc_if.sv
// link between the framer port block and the system-side backplane logic
// assumes one clock shared by both ends; multifunction pins are in/out/enable triples, clock pins have an enable only
`timescale 1ns/1ps
`default_nettype none
interface mpc_if;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic [7:0] rdata;
    logic [3:0] rx_pin_out;
    logic [3:0] rx_pin_oe;
    logic [3:0] rx_pin_in;
    logic [3:0] tx_pin_out;
    logic [3:0] tx_pin_oe;
    logic [3:0] tx_pin_in;
    logic sys_rx_clk_oe;
    logic rx_clk_oe;
    logic line_tristate;
    modport dev (input addr, input wdata, input wr, input rd,
        output rdata, output rx_pin_out, output rx_pin_oe,
        input rx_pin_in, output tx_pin_out, output tx_pin_oe,
        input tx_pin_in, output sys_rx_clk_oe, output rx_clk_oe,
        output line_tristate);
    modport sys (output addr, output wdata, output wr, output rd,
        input rdata, input rx_pin_out, input rx_pin_oe,
        output rx_pin_in, input tx_pin_out, input tx_pin_oe,
        output tx_pin_in, input sys_rx_clk_oe, input rx_clk_oe,
        input line_tristate);
endinterface : mpc_if
`default_nettype wire

// File: hdl/mpc_dev.sv
// framer end: port configuration registers and multifunction pin muxing
// assumes mpc_regs.svh, mpc_pkg and a 100 MHz clock with synchronous reset
//
// Notes on behaviour
// - all multifunction pins are inputs after reset
// - function code also sets pin direction
// - registers one to four drive ports A-D
// - receive sync input chosen once only
// - receive sync input excludes frame marker
// - frame marker high one bit at offset
// - internal option gives active-low sync pulse
// - marker high at each multiframe start
// - marker during selected receive time slots
// - signaling data aligned to receive slots
// - marker on spare bit positions
// - freeze on alarms, held one multiframe; here held MF_BITS - 1 bit times, one bit short
// - low 488 ns frame pulse when synchronous
// - each transmit input function chosen once
// - avoid sync and multiframe sync together
// - multiframe sync input sets transmit frame
// - polarity bit sets multiframe sync level
// - signaling input, optionally gated by marker
// - system supplies transmit clock when needed
// - transmit multiframe, slot and spare markers
// - line clock output at 2.048 MHz
// - tristate input ORed with register bit
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "mpc_regs.svh"
module mpc_dev #(
    parameter int RX_OFFSET = 0,
    parameter int TX_OFFSET = 0,
    parameter logic [31:0] RX_SLOTS = 32'h0001_0000,
    parameter logic [31:0] TX_SLOTS = 32'h0001_0000
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    mpc_if.dev link,
    input wire logic rx_sync_i,
    input wire logic rx_alarm_i,
    input wire logic rx_sig_i,
    output logic [7:0] tx_sig_o,
    output logic tx_mf_start_o,
    output logic tx_sig_valid_o
);
    import mpc_pkg::*;
    localparam int BIT_CYC = `MPC_BIT_CYC;
    localparam int MF_BITS = `MPC_BITS_FRAME * `MPC_FRAMES_MF;

    typedef struct packed {
        mpc_byte_t [3:0] port_cfg;
        mpc_byte_t clk_cfg;
        mpc_byte_t ctrl;
        mpc_byte_t rdata;
        logic [5:0] div;
        logic [11:0] bitpos;
        logic [11:0] frz_cnt;
        logic frz;
        logic [3:0] rx_out;
        logic [3:0] rx_oe;
        logic [3:0] tx_out;
        logic [3:0] tx_oe;
        logic sclk_oe;
        logic rclk_oe;
        logic tri_out;
        logic [7:0] tx_sig;
        logic tx_mf;
        logic tx_sig_v;
        logic [2:0] tx_bit;
    } mpc_dev_s;
    mpc_dev_s st_reg;
    mpc_dev_s st_next;

    function automatic logic rx_is_out(input mpc_byte_t cfg);
        return cfg[`MPC_RX_SEL_MSB:`MPC_RX_SEL_LSB] != MPC_RX_SYNC_IN;
    endfunction : rx_is_out

    function automatic logic tx_is_out(input mpc_byte_t cfg);
        mpc_tx_sel_t s;
        s = cfg[`MPC_TX_SEL_MSB:`MPC_TX_SEL_LSB];
        return s >= MPC_TX_MF_START && s <= MPC_TX_LINE_CLK;
    endfunction : tx_is_out

    function automatic logic is_spare(input logic [11:0] bp);
        // spare bits: bits 3..7 of slot 0 in odd frames
        return bp[8] && bp[7:3] == 5'h00 && bp[2:0] >= 3'h3;
    endfunction : is_spare

    logic [7:0] slot;
    logic [7:0] rx_phase;
    logic [7:0] tx_phase;
    logic mf_sync;
    logic sig_gate;
    logic [3:0] rx_fn_out;
    logic [3:0] tx_fn_out;

    always_comb begin
        st_next = st_reg;
        slot = {3'h0, st_reg.bitpos[7:3]};
        rx_phase = 8'(st_reg.bitpos[7:0] - 8'(RX_OFFSET));
        tx_phase = 8'(st_reg.bitpos[7:0] - 8'(TX_OFFSET));
        mf_sync = 1'b0;
        sig_gate = 1'b0;
        rx_fn_out = 4'h0;
        tx_fn_out = 4'h0;
        // ----------------------------------------------------------------
        // register access
        // ----------------------------------------------------------------
        st_next.rdata = 8'h00;
        if (link.wr) begin
            for (int i = 0; i < 4; i++) begin
                if (link.addr == 8'(`MPC_OFF_PORT_CFG_A + i)) begin
                    st_next.port_cfg[i] = link.wdata;
                end
            end
            if (link.addr == `MPC_OFF_PORT_CFG_CLK) begin
                st_next.clk_cfg = link.wdata;
                st_next.clk_cfg[`MPC_RSVD_BIT] = 1'b0;
            end
            if (link.addr == `MPC_OFF_CTRL) begin
                st_next.ctrl = link.wdata;
            end
        end
        if (link.rd) begin
            for (int i = 0; i < 4; i++) begin
                if (link.addr == 8'(`MPC_OFF_PORT_CFG_A + i)) begin
                    st_next.rdata = st_reg.port_cfg[i];
                end
            end
            if (link.addr == `MPC_OFF_PORT_CFG_CLK) begin
                st_next.rdata = st_reg.clk_cfg;
            end
            if (link.addr == `MPC_OFF_CTRL) begin
                st_next.rdata = st_reg.ctrl;
            end
            if (link.addr == `MPC_OFF_STATUS) begin
                st_next.rdata = {st_reg.frz, rx_sync_i, 6'h00};
            end
        end
        // ----------------------------------------------------------------
        // bit timing
        // ----------------------------------------------------------------
        if (st_reg.div == 6'(BIT_CYC - 1)) begin
            st_next.div = 6'h00;
            st_next.bitpos = 12'(st_reg.bitpos + 12'h001);
        end else begin
            st_next.div = 6'(st_reg.div + 6'h01);
        end
        for (int p = 0; p < 4; p++) begin
            if (st_reg.port_cfg[p][`MPC_TX_SEL_MSB:`MPC_TX_SEL_LSB]
                    == MPC_TX_MF_SYNC_IN &&
                    (link.tx_pin_in[p] ==
                    st_reg.clk_cfg[`MPC_POL_BIT])) begin
                mf_sync = 1'b1;
            end
            if (st_reg.port_cfg[p][`MPC_TX_SEL_MSB:`MPC_TX_SEL_LSB]
                    == MPC_TX_SIG_MARK && link.tx_pin_out[p]) begin
                sig_gate = 1'b1;
            end
        end
        if (mf_sync) begin
            st_next.bitpos = 12'(TX_OFFSET);
            st_next.div = 6'h00;
        end
        // ----------------------------------------------------------------
        // freeze: held for MF_BITS - 1 bit times after alarm, one bit short of a multiframe
        // ----------------------------------------------------------------
        if (rx_alarm_i) begin
            st_next.frz = 1'b1;
            st_next.frz_cnt = 12'(MF_BITS - 1);
        end else if (st_reg.frz_cnt != 12'h000) begin
            if (st_reg.div == 6'(BIT_CYC - 1)) begin
                st_next.frz_cnt = 12'(st_reg.frz_cnt - 12'h001);
            end
        end else begin
            st_next.frz = 1'b0;
        end
        // ----------------------------------------------------------------
        // transmit signaling capture
        // ----------------------------------------------------------------
        st_next.tx_sig_v = 1'b0;
        st_next.tx_mf = st_reg.bitpos == 12'h000;
        for (int p = 0; p < 4; p++) begin
            if (st_reg.port_cfg[p][`MPC_TX_SEL_MSB:`MPC_TX_SEL_LSB]
                    == MPC_TX_SIG_IN && st_reg.div == 6'h00 &&
                    (!st_reg.ctrl[`MPC_CTRL_TX_SIGNALING_SLOT_MARKER_BIT] || sig_gate)) begin
                st_next.tx_sig[st_reg.tx_bit] = link.tx_pin_in[p];
                st_next.tx_bit = 3'(st_reg.tx_bit - 3'h1);
                st_next.tx_sig_v = st_reg.tx_bit == 3'h0;
            end
        end
        // ----------------------------------------------------------------
        // pin functions and directions
        // ----------------------------------------------------------------
        st_next.tri_out = st_reg.ctrl[`MPC_CTRL_XLT_BIT];
        for (int p = 0; p < 4; p++) begin
            unique case (st_reg.port_cfg[p][`MPC_RX_SEL_MSB:`MPC_RX_SEL_LSB])
                MPC_RX_SYNC_IN: rx_fn_out[p] = 1'b0;
                MPC_RX_FRAME_MARK: rx_fn_out[p] =
                    st_reg.ctrl[`MPC_CTRL_INTERNAL_SYNC_PULSE_SEL_BIT] ?
                    (st_reg.bitpos[7:0] != 8'h00) :
                    (rx_phase == 8'h00);
                MPC_RX_MF_START: rx_fn_out[p] =
                    st_reg.bitpos[11:0] == 12'h000 ||
                    (!st_reg.ctrl[`MPC_CTRL_CASMF_BIT] &&
                    st_reg.bitpos[8:0] == 9'h000);
                MPC_RX_SIG_MARK: rx_fn_out[p] = RX_SLOTS[slot[4:0]];
                MPC_RX_SIG_OUT: rx_fn_out[p] = rx_sig_i;
                MPC_RX_SPARE_MARK:
                    rx_fn_out[p] = is_spare(st_reg.bitpos);
                MPC_RX_FREEZE: rx_fn_out[p] = st_reg.frz ||
                    st_reg.ctrl[`MPC_CTRL_FFS_BIT];
                MPC_RX_FRAME_PULSE: rx_fn_out[p] =
                    !(rx_sync_i && st_reg.bitpos[7:0] == 8'h00);
            endcase
            case (st_reg.port_cfg[p][`MPC_TX_SEL_MSB:`MPC_TX_SEL_LSB])
                MPC_TX_MF_START:
                    tx_fn_out[p] = st_reg.bitpos == 12'h000;
                MPC_TX_SIG_MARK:
                    tx_fn_out[p] = TX_SLOTS[tx_phase[7:3]];
                MPC_TX_SPARE_MARK:
                    tx_fn_out[p] = is_spare(st_reg.bitpos);
                MPC_TX_LINE_CLK:
                    tx_fn_out[p] = st_reg.div < 6'(BIT_CYC / 2);
                MPC_TX_TRISTATE: begin
                    tx_fn_out[p] = 1'b0;
                    if (link.tx_pin_in[p]) begin
                        st_next.tri_out = 1'b1;
                    end
                end
                default: tx_fn_out[p] = 1'b0;
            endcase
            st_next.rx_oe[p] = rx_is_out(st_reg.port_cfg[p]);
            st_next.tx_oe[p] = tx_is_out(st_reg.port_cfg[p]);
        end
        st_next.rx_out = rx_fn_out;
        st_next.tx_out = tx_fn_out;
        st_next.sclk_oe = st_reg.clk_cfg[`MPC_SYSRX_DIR_BIT];
        st_next.rclk_oe = st_reg.clk_cfg[`MPC_RXCLK_DIR_BIT];
        if (sys_rst_i) begin
            st_next = '0;
            st_next.port_cfg = {4{`MPC_RST_PORT_CFG}};
            st_next.clk_cfg = `MPC_RST_CLK_CFG;
            st_next.ctrl = `MPC_RST_CTRL;
            st_next.tx_bit = 3'h7;
        end
    end

    always_ff @(posedge clk_i) begin
        st_reg <= st_next;
    end

    assign link.rdata = st_reg.rdata;
    assign link.rx_pin_out = st_reg.rx_out;
    assign link.rx_pin_oe = st_reg.rx_oe;
    assign link.tx_pin_out = st_reg.tx_out;
    assign link.tx_pin_oe = st_reg.tx_oe;
    assign link.sys_rx_clk_oe = st_reg.sclk_oe;
    assign link.rx_clk_oe = st_reg.rclk_oe;
    assign link.line_tristate = st_reg.tri_out;
    assign tx_sig_o = st_reg.tx_sig;
    assign tx_mf_start_o = st_reg.tx_mf;
    assign tx_sig_valid_o = st_reg.tx_sig_v;
endmodule : mpc_dev
`default_nettype wire

// File: hdl/mpc_sys.sv
// system end: drives register accesses and the input pin functions
// assumes the framer end keeps its own directions; one shared clock
`timescale 1ns/1ps
`default_nettype none
`include "mpc_regs.svh"
module mpc_sys (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    mpc_if.sys link,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [3:0] rx_pin_i,
    input wire logic [3:0] tx_pin_i,
    output logic [7:0] rdata_o,
    output logic rdata_valid_o,
    output logic [3:0] rx_pin_o,
    output logic [3:0] tx_pin_o
);
    import mpc_pkg::*;
    typedef struct packed {
        mpc_host_state_e state;
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
        logic [7:0] rdata;
        logic rvalid;
        logic [3:0] rx_in;
        logic [3:0] tx_in;
        logic [3:0] rx_seen;
        logic [3:0] tx_seen;
    } mpc_sys_s;
    mpc_sys_s st_reg;
    mpc_sys_s st_next;

    always_comb begin
        st_next = st_reg;
        st_next.wr = wr_i;
        st_next.rd = rd_i && !wr_i;
        st_next.addr = addr_i;
        st_next.wdata = wdata_i;
        // reserved clock-config bit always written as zero
        if (wr_i && addr_i == `MPC_OFF_PORT_CFG_CLK) begin
            st_next.wdata[`MPC_RSVD_BIT] = 1'b0;
        end
        // state follows the request on the link, so read lines up with
        // the cycle in which the framer end shows its read data
        unique case (st_reg.state)
            MPC_H_IDLE, MPC_H_WRITE, MPC_H_READ: st_next.state =
                st_reg.wr ? MPC_H_WRITE :
                (st_reg.rd ? MPC_H_READ : MPC_H_IDLE);
        endcase
        // read data appear three cycles after the strobe here
        st_next.rvalid = st_reg.state == MPC_H_READ;
        st_next.rdata = st_reg.state == MPC_H_READ ? link.rdata : 8'h00;
        // drive pins only where the framer leaves them as inputs
        st_next.rx_in = rx_pin_i & ~link.rx_pin_oe;
        st_next.tx_in = tx_pin_i & ~link.tx_pin_oe;
        st_next.rx_seen = link.rx_pin_out & link.rx_pin_oe;
        st_next.tx_seen = link.tx_pin_out & link.tx_pin_oe;
        if (sys_rst_i) begin
            st_next = '0;
            st_next.state = MPC_H_IDLE;
        end
    end

    always_ff @(posedge clk_i) begin
        st_reg <= st_next;
    end

    assign link.addr = st_reg.addr;
    assign link.wdata = st_reg.wdata;
    assign link.wr = st_reg.wr;
    assign link.rd = st_reg.rd;
    assign link.rx_pin_in = st_reg.rx_in;
    assign link.tx_pin_in = st_reg.tx_in;
    assign rdata_o = st_reg.rdata;
    assign rdata_valid_o = st_reg.rvalid;
    assign rx_pin_o = st_reg.rx_seen;
    assign tx_pin_o = st_reg.tx_seen;
endmodule : mpc_sys
`default_nettype wire

// File: verif/mpc_assertions.sv
// checker for the link between the framer end and the system end
// assumes one clock and a synchronous active-high reset on both ends
`timescale 1ns/1ps
`default_nettype none
`include "mpc_regs.svh"
module mpc_assertions (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] rdata,
    input wire logic [3:0] rx_pin_oe,
    input wire logic [3:0] tx_pin_oe,
    input wire logic sys_rx_clk_oe,
    input wire logic rx_clk_oe,
    input wire logic line_tristate
);
    // ------------------------------------------------------------
    // shadow of the written configuration
    // ------------------------------------------------------------
    logic [7:0] cfg_reg [0:4];
    logic [7:0] cfg_d_reg [0:4];
    logic [7:0] exp_reg;
    logic [3:0] exp_rx_oe;
    logic [3:0] exp_tx_oe;
    logic in_cfg;
    logic mapped;
    assign in_cfg = addr >= `MPC_OFF_PORT_CFG_A &&
        addr <= `MPC_OFF_PORT_CFG_CLK;
    assign mapped = in_cfg || addr == `MPC_OFF_CTRL ||
        addr == `MPC_OFF_STATUS;
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            exp_rx_oe[i] = cfg_d_reg[i][6:4] != 3'h0;
            exp_tx_oe[i] = cfg_d_reg[i][3:2] == 2'h1;
        end
    end
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            cfg_reg <= '{default: 8'h00};
            cfg_d_reg <= '{default: 8'h00};
            exp_reg <= 8'h00;
        end else begin
            cfg_d_reg <= cfg_reg;
            exp_reg <= in_cfg ? cfg_reg[addr[2:0]] : 8'h00;
            if (wr && in_cfg) begin
                cfg_reg[addr[2:0]] <= addr[2] ? (wdata & 8'hfb) : wdata;
            end
        end
    end
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    property p_rst;
        disable iff (1'b0) sys_rst_i |=> (rx_pin_oe == 4'h0 &&
            tx_pin_oe == 4'h0 && rdata == 8'h00);
    endproperty
    property p_rx_dir; rx_pin_oe == exp_rx_oe; endproperty
    property p_tx_dir; tx_pin_oe == exp_tx_oe; endproperty
    property p_clk_dir;
        {sys_rx_clk_oe, rx_clk_oe} == cfg_d_reg[4][1:0];
    endproperty
    property p_rd_cfg;
        rd && in_cfg && !addr[2] |=> rdata[6:0] == exp_reg[6:0];
    endproperty
    property p_rd_clk;
        rd && addr == `MPC_OFF_PORT_CFG_CLK |=> rdata[3:0] == exp_reg[3:0];
    endproperty
    property p_rd_idle; !rd |=> rdata == 8'h00; endproperty
    property p_unmapped; rd && !mapped |=> rdata == 8'h00; endproperty
    property p_tristate;
        wr && addr == `MPC_OFF_CTRL && wdata[4] |-> ##[2:4] line_tristate;
    endproperty
    a_rst: assert property (p_rst)
        else $error("pins not inputs after reset");
    a_rx_dir: assert property (p_rx_dir)
        else $error("rx pin direction");
    a_tx_dir: assert property (p_tx_dir)
        else $error("tx pin direction");
    a_clk_dir: assert property (p_clk_dir)
        else $error("clock pin dir");
    a_rd_cfg: assert property (p_rd_cfg)
        else $error("port cfg readback");
    a_rd_clk: assert property (p_rd_clk)
        else $error("clock cfg readback");
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data not idle");
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read");
    a_tristate: assert property (p_tristate)
        else $error("tristate late");
    c_rd_clk: cover property (rd && addr == `MPC_OFF_PORT_CFG_CLK);
    c_sync_in: cover property (wr && in_cfg && wdata[6:4] == 3'h0);
    c_tristate: cover property ($rose(line_tristate));
endmodule : mpc_assertions
`default_nettype wire

// File: verif/tb_mpc.sv
// self-checking bench: framer end and system end joined by the link
// assumes 100 MHz clock and synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module tb_mpc;
    import mpc_pkg::*;
    logic clk_i = 1'b0, sys_rst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0;
    logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, rdata_o, tx_sig_o;
    logic [3:0] rx_pin_i = 4'h0, tx_pin_i = 4'h0, rx_pin_o, tx_pin_o;
    logic rx_alarm_i = 1'b0, rdata_valid_o, tx_mf_start_o, tx_sig_valid_o;
    logic rx_sync_i = 1'b1, rx_sig_i = 1'b0;
    logic [31:0] seed = 32'd28;
    logic [7:0] mdl [0:255];
    int errors = 0, checked = 0;
    mpc_if i_mpc_if ();
    mpc_dev i_mpc_dev (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .link(i_mpc_if),
        .rx_sync_i(rx_sync_i), .rx_alarm_i(rx_alarm_i), .rx_sig_i(rx_sig_i),
        .tx_sig_o(tx_sig_o), .tx_mf_start_o(tx_mf_start_o),
        .tx_sig_valid_o(tx_sig_valid_o));
    mpc_sys i_mpc_sys (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .link(i_mpc_if),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
        .rx_pin_i(rx_pin_i), .tx_pin_i(tx_pin_i), .rdata_o(rdata_o),
        .rdata_valid_o(rdata_valid_o), .rx_pin_o(rx_pin_o),
        .tx_pin_o(tx_pin_o));
    mpc_assertions i_mpc_assertions (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .addr(i_mpc_if.addr), .wdata(i_mpc_if.wdata), .wr(i_mpc_if.wr),
        .rd(i_mpc_if.rd), .rdata(i_mpc_if.rdata),
        .rx_pin_oe(i_mpc_if.rx_pin_oe), .tx_pin_oe(i_mpc_if.tx_pin_oe),
        .sys_rx_clk_oe(i_mpc_if.sys_rx_clk_oe), .rx_clk_oe(i_mpc_if.rx_clk_oe),
        .line_tristate(i_mpc_if.line_tristate));
    initial begin
        forever #5 clk_i = ~clk_i;
    end
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs
    function automatic logic [7:0] rmask(input logic [7:0] a);
        if (a >= 8'h80 && a <= 8'h83) return 8'h7f;
        if (a == 8'h84) return 8'h0f;
        if (a == 8'h90) return 8'h1f;
        return 8'hff;
    endfunction : rmask
    function automatic logic [7:0] oe_exp(input logic tx);
        oe_exp = 8'h00;
        for (int i = 0; i < 4; i++) begin
            oe_exp[i] = tx ? mdl[8'h80 + i][3:2] == 2'h1 :
                mdl[8'h80 + i][6:4] != 3'h0;
        end
    endfunction : oe_exp
    task automatic test_done();
        if (errors == 0 && checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : test_done
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp,
        input string what);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic rst_dut();
        sys_rst_i <= 1'b1;
        repeat (8) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        mdl = '{default: 8'h00};
    endtask : rst_dut
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
        if (rmask(a) != 8'hff) mdl[a] = (a == 8'h84) ? (d & 8'hfb) : d;
    endtask : wr_reg
    task automatic rd_chk(input logic [7:0] a);
        int n;
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        for (n = 0; n < 8; n++) begin
            #1;
            if (rdata_valid_o === 1'b1) break;
            @(posedge clk_i);
        end
        if (n == 8) begin
            errors++;
            test_done();
        end
        chk(rdata_o & rmask(a), mdl[a] & rmask(a), "read data");
    endtask : rd_chk
    task automatic settle();
        repeat (8) @(posedge clk_i);
        #1;
    endtask : settle
    task automatic check_dirs();
        settle();
        chk({4'h0, i_mpc_if.rx_pin_oe}, oe_exp(1'b0), "rx_pin_oe");
        chk({4'h0, i_mpc_if.tx_pin_oe}, oe_exp(1'b1), "tx_pin_oe");
        chk({6'h0, i_mpc_if.sys_rx_clk_oe, i_mpc_if.rx_clk_oe},
            {6'h0, mdl[8'h84][1:0]}, "clk_oe");
    endtask : check_dirs
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        logic [31:0] r;
        logic [7:0] a;
        logic [7:0] d;
        int n;
        rst_dut();
        for (int k = 8'h80; k <= 8'h84; k++) rd_chk(k[7:0]);
        rd_chk(8'h90);
        check_dirs();
        for (int p = 0; p < 4; p++) wr_reg(8'h80 + p[7:0], 8'h24);
        for (int p = 0; p < 4; p++) begin
            for (int k = 0; k < 16; k++) begin
                wr_reg(8'h80 + p[7:0], {1'b0, k[2:0], k[3:0]});
                rd_chk(8'h80 + p[7:0]);
                check_dirs();
            end
            wr_reg(8'h80 + p[7:0], 8'h24);
        end
        for (int n = 0; n < 24; n++) begin
            r = xs();
            a = r[10:8] < 3'h4 ? {6'h20, r[9:8]} : r[10:8] == 3'h4 ? 8'h84 :
                r[10:8] == 3'h5 ? 8'h90 : {1'b0, r[22:16]};
            d = a < 8'h84 ? {1'b0, 3'(1 + r[2:0] % 7), 4'(4 + r[6:3] % 5)} :
                r[7:0] & (a == 8'h90 ? 8'h1f : 8'hfb);
            rx_pin_i <= r[27:24];
            tx_pin_i <= r[31:28];
            wr_reg(a, d);
            rd_chk(a);
            check_dirs();
        end
        wr_reg(8'h84, 8'h07);
        rd_chk(8'h84);
        check_dirs();
        wr_reg(8'h80, 8'h64);
        wr_reg(8'h81, 8'h28);
        wr_reg(8'h82, 8'h21);
        wr_reg(8'h90, 8'h02);
        settle();
        chk({7'h0, rx_pin_o[0]}, 8'h01, "forced freeze");
        wr_reg(8'h90, 8'h00);
        rx_alarm_i <= 1'b1;
        settle();
        chk({7'h0, rx_pin_o[0]}, 8'h01, "alarm freeze");
        rx_alarm_i <= 1'b0;
        repeat (100) @(posedge clk_i);
        #1;
        chk({7'h0, rx_pin_o[0]}, 8'h01, "freeze hold");
        tx_pin_i <= 4'h2;
        settle();
        chk({7'h0, i_mpc_if.line_tristate}, 8'h01, "tristate pin");
        tx_pin_i <= 4'h0;
        settle();
        chk({7'h0, i_mpc_if.line_tristate}, 8'h00, "tristate off");
        wr_reg(8'h90, 8'h10);
        settle();
        chk({7'h0, i_mpc_if.line_tristate}, 8'h01, "tristate bit");
        wr_reg(8'h90, 8'h00);
        wr_reg(8'h83, 8'h44);
        for (int k = 0; k < 4; k++) begin
            r = xs();
            rx_sig_i <= r[0];
            settle();
            chk({7'h0, rx_pin_o[3]}, {7'h0, r[0]}, "rx signaling");
        end
        wr_reg(8'h83, 8'h74);
        for (int pol = 0; pol < 2; pol++) begin
            wr_reg(8'h84, pol[0] ? 8'h08 : 8'h00);
            tx_pin_i <= pol[0] ? 4'h4 : 4'h0;
            settle();
            chk({7'h0, tx_mf_start_o}, 8'h01, "mf sync active");
            chk({7'h0, tx_pin_o[0]}, 8'h01, "mf start pin");
            chk({7'h0, rx_pin_o[3]}, 8'h00, "frame pulse");
            tx_pin_i <= pol[0] ? 4'h0 : 4'h4;
            repeat (60) @(posedge clk_i);
            #1;
            chk({7'h0, tx_mf_start_o}, 8'h00, "mf sync idle");
            chk({7'h0, tx_pin_o[0]}, 8'h00, "mf start pin idle");
            chk({7'h0, rx_pin_o[3]}, 8'h01, "frame pulse idle");
        end
        rx_sync_i <= 1'b0;
        tx_pin_i <= 4'h4;
        settle();
        chk({7'h0, rx_pin_o[3]}, 8'h01, "pulse out of sync");
        wr_reg(8'h81, 8'h22);
        for (int v = 0; v < 2; v++) begin
            tx_pin_i <= v[0] ? 4'h0 : 4'hf;
            n = 0;
            repeat (500) begin
                @(posedge clk_i);
                #1;
                n += tx_sig_valid_o;
            end
            chk(tx_sig_o, v[0] ? 8'h00 : 8'hff, "tx signaling");
            chk({7'h0, n != 0}, 8'h01, "signaling valid");
        end
        rst_dut();
        rd_chk(8'h80);
        check_dirs();
        test_done();
    end
endmodule : tb_mpc
`default_nettype wire
